// file: pkg/drs_defs.svh
`ifndef DRS_DEFS_SVH
`define DRS_DEFS_SVH

// ----------------------------------------------------------------------------
// register map (word index on the plain register port)
// ----------------------------------------------------------------------------
`define DRS_A_CTRL       4'h0
`define DRS_A_SS_SEL     4'h1
`define DRS_A_SS_ILIM    4'h2
`define DRS_A_SS_PGAIN   4'h3
`define DRS_A_SS_IGAIN   4'h4
`define DRS_A_AR_TRIES   4'h5
`define DRS_A_AR_DELAY   4'h6
`define DRS_A_MOTOR      4'h7
`define DRS_A_STATUS     4'h8
`define DRS_A_RETRY_LEFT 4'h9
`define DRS_A_SPEED      4'hA
`define DRS_A_RATED      4'hB

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define DRS_CTRL_PON      0
`define DRS_CTRL_FRR      1
`define DRS_CTRL_SRC_LO   2
`define DRS_CTRL_OTF      4
`define DRS_CTRL_RLF      5
`define DRS_SS_BIT_PON    3
`define DRS_SS_BIT_IPF    2
`define DRS_SS_BIT_FRS    1
`define DRS_SS_BIT_ACC    0

// ----------------------------------------------------------------------------
// reset values and limits
// ----------------------------------------------------------------------------
`define DRS_SRC_TERM1     2'h1
`define DRS_SRC_TERM2     2'h2
`define DRS_ILIM_MIN      8'h50
`define DRS_ILIM_MAX      8'hC8
`define DRS_ILIM_DEF      8'h64
`define DRS_GAIN_MAX      14'h270F
`define DRS_PGAIN_DEF     14'h0064
`define DRS_IGAIN_DEF     14'h00C8
`define DRS_TRIES_MAX     4'hA
`define DRS_DELAY_MAX     10'h258
`define DRS_DELAY_DEF     10'h00A
`define DRS_MOTOR_MAX     3'h6
`define DRS_MOTOR_DEF     3'h6
`define DRS_POLE_MIN      4'h2
`define DRS_POLE_MAX      4'hC
`define DRS_POLE_DEF      4'h4

// ----------------------------------------------------------------------------
// timing: delay unit 0.1 s, fault-free run 30 s, clock 100 MHz
// ----------------------------------------------------------------------------
`define DRS_CLK_HZ        100000000
`define DRS_TENTH_MS      100
`define DRS_CLEAN_RUN_S   30

`endif

// file: pkg/drs_pkg.sv
package drs_pkg;
  typedef enum logic [2:0] {
    DRS_IDLE, DRS_RUN, DRS_FAULT, DRS_WAIT, DRS_SEARCH
  } drs_state_e;

  typedef enum logic [1:0] {
    DRS_EV_PON, DRS_EV_IPF, DRS_EV_FRS, DRS_EV_ACC
  } drs_event_e;
endpackage : drs_pkg

// file: hdl/drs_restart.sv
// Local design decisions: the strobed register port and the address map.
`timescale 1ns/1ps
`include "drs_defs.svh"
module drs_restart
  import drs_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = (`DRS_CLK_HZ / 1000) * `DRS_TENTH_MS,
  parameter int unsigned CLEAN_CYCLES = 32'(64'(`DRS_CLK_HZ) * `DRS_CLEAN_RUN_S)
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        run_cmd_pin,
  input  wire logic        power_ok_pin,
  input  wire logic        fault_pin,
  input  wire logic        fault_reset,
  input  wire logic        overheat_trip,
  input  wire logic        low_voltage_trip,
  input  wire logic        external_trip,
  input  wire logic        hardware_trip,
  input  wire logic        undervoltage_trip,
  input  wire logic        drive_disable_input,
  input  wire logic        arm_short_trip,
  input  wire logic        instant_power_fail,
  input  wire logic        accelerating,
  input  wire logic        speed_matched,
  input  wire logic [15:0] out_freq_centihz,
  output logic             restart_req,
  output logic             auto_reset_req,
  output logic             run_enable,
  output logic             search_active,
  output logic [1:0]       search_event,
  output logic             multi_function_output,
  output logic             multi_function_relay
);

  // zero-length timers would let a retry fire with no delay at all
  if (TENTH_CYCLES < 1 || CLEAN_CYCLES < 1) begin : g_bad_timing
    $error("drs_restart: timing counts must be at least one cycle");
  end

  // --------------------------------------------------------------------------
  // state
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic [1:0]  run_sync;
    logic [1:0]  pwr_sync;
    logic [1:0]  flt_sync;
    logic        run_q;
    logic        pwr_q;
    logic        flt_q;
    logic        armed;
    drs_state_e  st;
    logic        power_on_start_select;
    logic        fault_reset_restart_select;
    logic [1:0]  run_command_source;
    logic        output_terminal_function;
    logic        relay_output_function;
    logic [3:0]  speed_search_select;
    logic [7:0]  speed_search_current_limit;
    logic [13:0] speed_search_p_gain;
    logic [13:0] speed_search_i_gain;
    logic [3:0]  auto_restart_attempts;
    logic [9:0]  auto_restart_delay;
    logic [2:0]  motor_capacity_select;
    logic [3:0]  motor_pole_count;
    logic [3:0]  retry_left;
    logic [31:0] tick;
    logic [9:0]  tenths;
    logic [31:0] clean;
    logic [1:0]  ev;
    logic [15:0] rated_ma;
    logic [31:0] rdata;
    logic        restart_req;
    logic        auto_reset_req;
    logic        search_active;
    logic        mfo;
    logic        mfr;
    logic        run_en;
  } drs_s;

  drs_s r;
  drs_s next_r;

  // motor capacity code to rated current in 0.1 A
  function automatic logic [15:0] rated_of(input logic [2:0] cap);
    case (cap)
      3'h0:    rated_of = 16'h000B;
      3'h1:    rated_of = 16'h0012;
      3'h2:    rated_of = 16'h0020;
      3'h3:    rated_of = 16'h0036;
      3'h4:    rated_of = 16'h0058;
      3'h5:    rated_of = 16'h0082;
      default: rated_of = 16'h0107;
    endcase
  endfunction : rated_of

  // clamp helper used by every ranged setting
  function automatic logic [13:0] clamp(input logic [13:0] v, input logic [13:0] lo,
                                        input logic [13:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction : clamp

  logic        term_src;
  logic        hard_latched;
  logic        inhibit;
  logic [31:0] rpm;

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.run_sync = {r.run_sync[0], run_cmd_pin};
    next_r.pwr_sync = {r.pwr_sync[0], power_ok_pin};
    next_r.flt_sync = {r.flt_sync[0], fault_pin};
    next_r.run_q = r.run_sync[1];
    next_r.pwr_q = r.pwr_sync[1];
    next_r.flt_q = r.flt_sync[1];
    next_r.restart_req = 1'b0;
    next_r.auto_reset_req = 1'b0;
    term_src = (r.run_command_source == `DRS_SRC_TERM1) ||
               (r.run_command_source == `DRS_SRC_TERM2);
    hard_latched = overheat_trip | low_voltage_trip | external_trip | hardware_trip;
    inhibit = undervoltage_trip | drive_disable_input | arm_short_trip;
    rpm = (32'(out_freq_centihz) * 32'd120) / (32'(r.motor_pole_count) * 32'd100);

    // run removed re-arms a plain start
    if (!r.run_q) begin
      next_r.armed = 1'b1;
    end

    // register writes with range clamping
    if (reg_wr) begin
      if (reg_addr == `DRS_A_CTRL) begin
        next_r.power_on_start_select = reg_wdata[`DRS_CTRL_PON];
        next_r.fault_reset_restart_select = reg_wdata[`DRS_CTRL_FRR];
        next_r.run_command_source = reg_wdata[`DRS_CTRL_SRC_LO +: 2];
        next_r.output_terminal_function = reg_wdata[`DRS_CTRL_OTF];
        next_r.relay_output_function = reg_wdata[`DRS_CTRL_RLF];
      end else if (reg_addr == `DRS_A_SS_SEL) begin
        next_r.speed_search_select = reg_wdata[3:0];
      end else if (reg_addr == `DRS_A_SS_ILIM) begin
        next_r.speed_search_current_limit = 8'(clamp(14'(reg_wdata[7:0]),
          14'(`DRS_ILIM_MIN), 14'(`DRS_ILIM_MAX)));
      end else if (reg_addr == `DRS_A_SS_PGAIN) begin
        next_r.speed_search_p_gain = clamp(reg_wdata[13:0], 14'h0000, `DRS_GAIN_MAX);
      end else if (reg_addr == `DRS_A_SS_IGAIN) begin
        next_r.speed_search_i_gain = clamp(reg_wdata[13:0], 14'h0000, `DRS_GAIN_MAX);
      end else if (reg_addr == `DRS_A_AR_TRIES) begin
        next_r.auto_restart_attempts = 4'(clamp(14'(reg_wdata[3:0]), 14'h0000,
          14'(`DRS_TRIES_MAX)));
        next_r.retry_left = next_r.auto_restart_attempts;
      end else if (reg_addr == `DRS_A_AR_DELAY) begin
        next_r.auto_restart_delay = 10'(clamp(14'(reg_wdata[9:0]), 14'h0000,
          14'(`DRS_DELAY_MAX)));
      end else if (reg_addr == `DRS_A_MOTOR) begin
        next_r.motor_capacity_select = 3'(clamp(14'(reg_wdata[2:0]), 14'h0000,
          14'(`DRS_MOTOR_MAX)));
        next_r.rated_ma = rated_of(next_r.motor_capacity_select);
        next_r.motor_pole_count = 4'(clamp(14'(reg_wdata[11:8]), 14'(`DRS_POLE_MIN),
          14'(`DRS_POLE_MAX)));
      end
    end

    // sequencer
    case (r.st)
      DRS_IDLE: begin
        if (r.pwr_sync[1] && !r.pwr_q && r.run_q) begin
          // power back with run held: only the option may start the motor
          if (r.power_on_start_select && term_src) begin
            next_r.restart_req = 1'b1;
            next_r.armed = 1'b0;
            next_r.ev = DRS_EV_PON;
            next_r.st = r.speed_search_select[`DRS_SS_BIT_PON] ? DRS_SEARCH : DRS_RUN;
          end else begin
            next_r.armed = 1'b0;
          end
        end else if (r.pwr_q && r.run_q && r.armed) begin
          // no plain start while the supply is absent
          next_r.restart_req = 1'b1;
          next_r.armed = 1'b0;
          next_r.ev = DRS_EV_ACC;
          next_r.st = (r.speed_search_select[`DRS_SS_BIT_ACC] && accelerating) ?
                      DRS_SEARCH : DRS_RUN;
        end
      end
      DRS_RUN: begin
        if (!r.run_q) begin
          next_r.st = DRS_IDLE;
          next_r.clean = '0;
        end else if (instant_power_fail && r.speed_search_select[`DRS_SS_BIT_IPF]) begin
          next_r.ev = DRS_EV_IPF;
          next_r.st = DRS_SEARCH;
        end else if (r.clean + 32'd1 >= CLEAN_CYCLES) begin
          next_r.clean = '0;
          if (r.retry_left < r.auto_restart_attempts) begin
            next_r.retry_left = r.retry_left + 4'h1;
          end
        end else begin
          next_r.clean = r.clean + 32'd1;
        end
      end
      DRS_SEARCH: begin
        if (speed_matched) begin
          next_r.st = DRS_RUN;
        end
      end
      DRS_FAULT: begin
        if (fault_reset) begin
          if (r.run_q && r.fault_reset_restart_select && term_src) begin
            next_r.restart_req = 1'b1;
            next_r.ev = DRS_EV_FRS;
            next_r.st = r.speed_search_select[`DRS_SS_BIT_FRS] ? DRS_SEARCH : DRS_RUN;
          end else begin
            next_r.armed = 1'b0;
            next_r.st = DRS_IDLE;
          end
        end else if (term_src && !hard_latched && !inhibit && r.retry_left != 4'h0) begin
          next_r.st = DRS_WAIT;
          next_r.tick = '0;
          next_r.tenths = '0;
        end
      end
      DRS_WAIT: begin
        if (hard_latched || inhibit) begin
          next_r.st = DRS_FAULT;
        end else if (r.tenths >= r.auto_restart_delay) begin
          next_r.auto_reset_req = 1'b1;
          next_r.restart_req = r.run_q;
          next_r.ev = DRS_EV_FRS;
          next_r.st = !r.run_q ? DRS_IDLE :
                      (r.speed_search_select[`DRS_SS_BIT_FRS] ? DRS_SEARCH : DRS_RUN);
        end else if (r.tick + 32'd1 >= TENTH_CYCLES) begin
          next_r.tick = '0;
          next_r.tenths = r.tenths + 10'h001;
        end else begin
          next_r.tick = r.tick + 32'd1;
        end
      end
      default: next_r.st = DRS_IDLE;
    endcase

    // a new fault overrides any state
    if (r.flt_sync[1] && !r.flt_q) begin
      next_r.st = DRS_FAULT;
      next_r.clean = '0;
      next_r.restart_req = 1'b0;
      if (r.retry_left != 4'h0) begin
        next_r.retry_left = r.retry_left - 4'h1;
      end
    end

    next_r.search_active = (next_r.st == DRS_SEARCH);
    next_r.mfo = next_r.search_active & r.output_terminal_function;
    next_r.mfr = next_r.search_active & r.relay_output_function;
    next_r.run_en = (next_r.st == DRS_RUN) || (next_r.st == DRS_SEARCH);

    // read data, one cycle after the strobe
    next_r.rdata = '0;
    if (reg_rd) begin
      if (reg_addr == `DRS_A_CTRL) begin
        next_r.rdata = 32'({r.relay_output_function, r.output_terminal_function,
                            r.run_command_source, r.fault_reset_restart_select,
                            r.power_on_start_select});
      end else if (reg_addr == `DRS_A_SS_SEL) begin
        next_r.rdata = 32'(r.speed_search_select);
      end else if (reg_addr == `DRS_A_SS_ILIM) begin
        next_r.rdata = 32'(r.speed_search_current_limit);
      end else if (reg_addr == `DRS_A_SS_PGAIN) begin
        next_r.rdata = 32'(r.speed_search_p_gain);
      end else if (reg_addr == `DRS_A_SS_IGAIN) begin
        next_r.rdata = 32'(r.speed_search_i_gain);
      end else if (reg_addr == `DRS_A_AR_TRIES) begin
        next_r.rdata = 32'(r.auto_restart_attempts);
      end else if (reg_addr == `DRS_A_AR_DELAY) begin
        next_r.rdata = 32'(r.auto_restart_delay);
      end else if (reg_addr == `DRS_A_MOTOR) begin
        next_r.rdata = 32'({r.motor_pole_count, 5'h00, r.motor_capacity_select});
      end else if (reg_addr == `DRS_A_STATUS) begin
        next_r.rdata = 32'({r.ev, r.search_active, r.st});
      end else if (reg_addr == `DRS_A_RETRY_LEFT) begin
        next_r.rdata = 32'(r.retry_left);
      end else if (reg_addr == `DRS_A_SPEED) begin
        next_r.rdata = rpm;
      end else if (reg_addr == `DRS_A_RATED) begin
        next_r.rdata = 32'(r.rated_ma);
      end
    end
  end

  // --------------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------------
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      r <= '0;
      r.st <= DRS_IDLE;
      r.speed_search_current_limit <= `DRS_ILIM_DEF;
      r.speed_search_p_gain <= `DRS_PGAIN_DEF;
      r.speed_search_i_gain <= `DRS_IGAIN_DEF;
      r.auto_restart_delay <= `DRS_DELAY_DEF;
      r.motor_capacity_select <= `DRS_MOTOR_DEF;
      r.motor_pole_count <= `DRS_POLE_DEF;
      r.rated_ma <= rated_of(`DRS_MOTOR_DEF);
      r.run_command_source <= `DRS_SRC_TERM1;
    end else begin
      r <= next_r;
    end
  end

  assign reg_rdata = r.rdata;
  assign restart_req = r.restart_req;
  assign auto_reset_req = r.auto_reset_req;
  assign run_enable = r.run_en;
  assign search_active = r.search_active;
  assign search_event = r.ev;
  assign multi_function_output = r.mfo;
  assign multi_function_relay = r.mfr;

  // --------------------------------------------------------------------------
  // checks
  // --------------------------------------------------------------------------
  a_retry_bounded: assert property (@(posedge clk_sys) disable iff (rst)
    r.retry_left <= r.auto_restart_attempts || $past(reg_wr))
    else $error("retry count above setting");
  a_fault_decrements: assert property (@(posedge clk_sys) disable iff (rst)
    (r.flt_sync[1] && !r.flt_q && r.retry_left != 4'h0 && !reg_wr) |=>
    r.retry_left == $past(r.retry_left) - 4'h1)
    else $error("fault did not take a retry");
  a_no_retry_hard: assert property (@(posedge clk_sys) disable iff (rst)
    (r.st == DRS_WAIT && (hard_latched || inhibit)) |=> r.st == DRS_FAULT)
    else $error("auto restart despite latched trip");
  a_src_gates_retry: assert property (@(posedge clk_sys) disable iff (rst)
    (r.st == DRS_FAULT && !term_src && !(r.flt_sync[1] && !r.flt_q)) |=> r.st != DRS_WAIT)
    else $error("retry without terminal source");
  a_search_output: assert property (@(posedge clk_sys) disable iff (rst)
    multi_function_output |-> (search_active && r.output_terminal_function))
    else $error("terminal shows search while idle");
  a_ilim_range: assert property (@(posedge clk_sys) disable iff (rst)
    r.speed_search_current_limit >= `DRS_ILIM_MIN &&
    r.speed_search_current_limit <= `DRS_ILIM_MAX)
    else $error("search current limit out of range");
  a_zero_no_retry: assert property (@(posedge clk_sys) disable iff (rst)
    (r.st == DRS_FAULT && r.retry_left == 4'h0 && !reg_wr) |=> r.st != DRS_WAIT)
    else $error("retry with none left");
  a_frr_restart: assert property (@(posedge clk_sys) disable iff (rst)
    (r.st == DRS_FAULT && fault_reset && !r.fault_reset_restart_select &&
     !(r.flt_sync[1] && !r.flt_q)) |=> (!restart_req ##1 !restart_req))
    else $error("restart after reset with option off");

endmodule : drs_restart

// file: bench/drs_motor_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// motor and control terminals seen from the restart sequencer
// ----------------------------------------------------------------------------
module drs_motor_model
  import drs_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       run_req,
  input  wire logic       power_req,
  input  wire logic       fault_req,
  input  wire logic       search_active,
  input  wire logic [7:0] match_delay,
  output logic            run_cmd_pin,
  output logic            power_ok_pin,
  output logic            fault_pin,
  output logic            speed_matched
);
  logic [7:0] spin_cnt;

  // terminal levels move on the falling edge, so they arrive unaligned to the sampling edge
  initial {run_cmd_pin, power_ok_pin, fault_pin} = 3'h0;
  always @(negedge clk_sys) begin
    run_cmd_pin  <= run_req;
    power_ok_pin <= power_req;
    fault_pin    <= fault_req;
  end

  // the motor needs match_delay cycles of searching before output and rotor agree
  always @(posedge clk_sys) begin
    if (rst || !search_active) spin_cnt <= 8'h00;
    else if (spin_cnt != 8'hFF) spin_cnt <= spin_cnt + 8'h01;
  end
  assign speed_matched = search_active && (spin_cnt >= match_delay);
endmodule : drs_motor_model

// file: bench/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import drs_pkg::*;
;
  localparam int TENTH = 10;
  logic clk_sys = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, fault_reset = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, rv;
  logic [6:0] trips = 7'h00;
  logic run_req = 1'b0, power_req = 1'b0, fault_req = 1'b0, accelerating = 1'b0, ipf = 1'b0;
  logic [15:0] out_freq_centihz = 16'h0000;
  logic [7:0] match_delay = 8'h03;
  logic run_cmd_pin, power_ok_pin, fault_pin, speed_matched, restart_req, auto_reset_req;
  logic run_enable, search_active, mfo, mfr;
  logic [1:0] search_event;
  logic [3:0] ev;
  int err_count = 0, total_checks = 0, m_left = 0, seed = 32'hcf5b504b, i;
  int ra[8] = '{2, 3, 4, 5, 6, 7, 9, 12};
  int rx[8] = '{'h64, 'h64, 'hC8, 0, 'hA, 'h406, 0, 0};

  always #5 clk_sys = ~clk_sys;
  assign ev = {~search_active, search_active, auto_reset_req, restart_req};

  drs_restart #(.TENTH_CYCLES(10), .CLEAN_CYCLES(50)) dut (
    .clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .run_cmd_pin(run_cmd_pin),
    .power_ok_pin(power_ok_pin), .fault_pin(fault_pin), .fault_reset(fault_reset),
    .overheat_trip(trips[0]), .low_voltage_trip(trips[1]), .external_trip(trips[2]),
    .hardware_trip(trips[3]), .undervoltage_trip(trips[4]),
    .drive_disable_input(trips[5]), .arm_short_trip(trips[6]), .instant_power_fail(ipf),
    .accelerating(accelerating), .speed_matched(speed_matched),
    .out_freq_centihz(out_freq_centihz), .restart_req(restart_req),
    .auto_reset_req(auto_reset_req), .run_enable(run_enable),
    .search_active(search_active), .search_event(search_event),
    .multi_function_output(mfo), .multi_function_relay(mfr));

  drs_motor_model motor (
    .clk_sys(clk_sys), .rst(rst), .run_req(run_req), .power_req(power_req),
    .fault_req(fault_req), .search_active(search_active), .match_delay(match_delay),
    .run_cmd_pin(run_cmd_pin), .power_ok_pin(power_ok_pin), .fault_pin(fault_pin),
    .speed_matched(speed_matched));

  // ----------------------------------------------------------------------------
  // checking and bus helpers
  // ----------------------------------------------------------------------------
  task stop_test();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test

  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a; reg_wdata <= d; reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr

  // read data stand only in the cycle after the strobe
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    reg_addr <= a; reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd

  // bounded watch of one event line; a missed expected event ends the run
  task wait_ev(input int w, input int lim, input logic want, input string nm);
    int n;
    logic hit;
    hit = 1'b0;
    for (n = 0; n < lim && !hit; n++) begin
      @(posedge clk_sys);
      #1 hit = ev[w];
    end
    chk(nm, {31'h0, hit}, {31'h0, want});
    if (want && !hit) stop_test();
  endtask : wait_ev

  task ctrl(input logic [1:0] src, input logic frr);
    wr(4'h0, 32'h31 | (src << 2) | (frr << 1));
  endtask : ctrl

  task left_chk();
    rd(4'h9, rv);
    chk("retry_left", rv, m_left);
  endtask : left_chk

  // the model decrements on every fault, floor zero; late trips land during the delay
  task do_fault(input logic retry, input logic [6:0] late = 7'h00);
    @(posedge clk_sys);
    fault_req <= 1'b1;
    repeat (5) @(posedge clk_sys);
    fault_req <= 1'b0;
    trips <= trips | late;
    m_left = (m_left > 0) ? m_left - 1 : 0;
    wait_ev(1, TENTH - 2, 1'b0, "early_auto_reset");
    wait_ev(1, TENTH + 15, retry, "auto_reset");
    left_chk();
  endtask : do_fault

  task recover();
    @(posedge clk_sys);
    fault_reset <= 1'b1; run_req <= 1'b0;
    @(posedge clk_sys);
    fault_reset <= 1'b0;
    wait_ev(0, 8, 1'b0, "restart_no_run");
    chk("run_off", {31'h0, run_enable}, 32'h0);
    @(posedge clk_sys);
    run_req <= 1'b1;
    wait_ev(0, 20, 1'b1, "restart_rerun");
  endtask : recover

  // ----------------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    for (i = 0; i < 8; i++) begin
      rd(ra[i][3:0], rv);
      chk("reset_value", rv, rx[i]);
    end
    wr(4'h2, 32'h10); rd(4'h2, rv); chk("ilim_low", rv, 32'h50);
    wr(4'h2, 32'hFF); rd(4'h2, rv); chk("ilim_high", rv, 32'hC8);
    wr(4'h3, 32'hFFFF); rd(4'h3, rv); chk("pgain_max", rv, 32'h270F);
    wr(4'h5, 32'hF); rd(4'h5, rv); chk("tries_max", rv, 32'hA);
    wr(4'h6, 32'h3FF); rd(4'h6, rv); chk("delay_max", rv, 32'h258);
    out_freq_centihz <= 16'd6000;
    for (i = 0; i < 3; i++) begin
      wr(4'h7, (32'(2 + 2 * i * i) << 8) | 32'h6);
      rd(4'hA, rv);
      chk("rpm", rv, 7200 / (2 + 2 * i * i));
    end
    $display("test registers done");
    wr(4'h6, 32'h1); wr(4'h5, 32'h2); m_left = 2; wr(4'h1, 32'h0); ctrl(2'h1, 1'b0);
    run_req <= 1'b1;
    repeat (10) @(posedge clk_sys);
    power_req <= 1'b1;
    wait_ev(0, 20, 1'b1, "power_on_restart");
    chk("run_enable", {31'h0, run_enable}, 32'h1);
    $display("test power on done");
    do_fault(1'b1);
    repeat (60) @(posedge clk_sys);
    m_left = (m_left < 2) ? m_left + 1 : 2;
    left_chk();
    repeat (60) @(posedge clk_sys);
    left_chk();
    do_fault(1'b1);
    do_fault(1'b0);
    recover();
    $display("test auto retry done");
    wr(4'h5, 32'hA); m_left = 10;
    do_fault(1'b0, 7'h20);
    recover();
    for (i = 0; i < 7; i++) begin
      trips <= 7'(1 << i);
      do_fault(1'b0);
      recover();
    end
    trips <= 7'h00;
    ctrl(($random(seed) & 1) ? 2'h3 : 2'h0, 1'b0);
    do_fault(1'b0);
    ctrl(2'h1, 1'b0);
    recover();
    $display("test inhibits done");
    wr(4'h5, 32'h0); m_left = 0; ctrl(2'h3, 1'b1);
    do_fault(1'b0);
    @(posedge clk_sys) fault_reset <= 1'b1;
    @(posedge clk_sys) fault_reset <= 1'b0;
    wait_ev(0, 10, 1'b0, "frr_wrong_source");
    ctrl(2'h1, 1'b1);
    recover();
    wr(4'h1, 32'h2);
    match_delay <= 8'(3 + ($random(seed) & 15));
    do_fault(1'b0);
    @(posedge clk_sys) fault_reset <= 1'b1;
    @(posedge clk_sys) fault_reset <= 1'b0;
    wait_ev(2, 10, 1'b1, "fault_search");
    chk("event", {30'h0, search_event}, 32'h2);
    chk("term_relay", {30'h0, mfo, mfr}, 32'h3);
    wait_ev(3, 40, 1'b1, "search_end");
    $display("test fault reset done");
    wr(4'h1, 32'h4);
    @(posedge clk_sys) ipf <= 1'b1;
    wait_ev(2, 10, 1'b1, "ipf_search");
    chk("event", {30'h0, search_event}, 32'h1);
    ipf <= 1'b0;
    wait_ev(3, 40, 1'b1, "ipf_end");
    // acceleration search belongs to a fresh start, so run is dropped first
    for (i = 0; i < 2; i++) begin
      wr(4'h1, (i == 0) ? 32'h1 : 32'hE);
      run_req <= 1'b0;
      repeat (8) @(posedge clk_sys);
      accelerating <= 1'b1;
      run_req <= 1'b1;
      wait_ev(2, 10, i == 0, "accel_search");
      if (i == 0) chk("event", {30'h0, search_event}, 32'h3);
      accelerating <= 1'b0;
      if (i == 0) wait_ev(3, 40, 1'b1, "accel_end");
    end
    $display("test speed search done");
    stop_test();
  end

  // hang guard
  initial begin
    repeat (100000) @(posedge clk_sys);
    err_count++;
    stop_test();
  end
endmodule : tb_top
